// ### debug_status_ack_control_bench.sv
`timescale 1ns/10ps
// Scenario bench for the status flags and acknowledge lengths
module debug_status_ack_control_bench;
  // Stimulus, host nets and observed outputs
  logic clk_i, reset_i, clk_en_i, secured_i, ssc_mode_i, wait_mode_i;
  logic stop_mode_i, nvm_init_i, processor_background_instruction_instr_i, breakpoint_i, erase_ok_i;
  logic erase_busy_i, cmd_valid_i, cmd_unimpl_i, cmd_seq_ok_i, ack_en_i;
  logic cmd_has_ack_i, csr_wr_i, enable_wr_i, enable_val_i, cmd_go_o;
  logic cmd_rejected_o, ready_o, enabled_o, active_o, unsecured_status_bit_o;
  logic [7:0] mem_rdata_i, csr_wdata_i, status_o, rdata_o;
  logic [6:0] ev;
  dsac_pkg::dsac_cmd_t cmd_class_i;
  dsac_pkg::dsac_ack_t ack_o, ack;
  int err_count, n_checks;
  wire stop_req_i = ev[0];
  wire ram_ecc_fault_i = ev[1];
  wire processor_background_instruction_cmd_i = ev[2];
  wire erase_done_i = ev[3];
  wire sync_i = ev[4];
  wire host_low_pend_i = ev[5];
  wire byte_rx_i = ev[6];

  dsac_debug_status dut (.clk_i, .clk_en_i, .reset_i, .secured_i,
    .ssc_mode_i, .wait_mode_i, .stop_req_i, .stop_mode_i, .ram_ecc_fault_i,
    .nvm_init_i, .processor_background_instruction_cmd_i, .processor_background_instruction_instr_i, .breakpoint_i, .erase_done_i,
    .erase_ok_i, .erase_busy_i, .sync_i, .host_low_pend_i, .byte_rx_i,
    .cmd_valid_i, .cmd_class_i, .cmd_unimpl_i, .cmd_seq_ok_i,
    .cmd_has_ack_i, .ack_en_i, .csr_wr_i, .csr_wdata_i, .enable_wr_i,
    .enable_val_i, .mem_rdata_i, .status_o, .rdata_o, .ack_o, .cmd_go_o,
    .cmd_rejected_o, .ready_o, .enabled_o, .active_o, .unsecured_status_bit_o);
  dsac_host_model host (.clk_i, .cmd_valid_i, .cmd_class_i, .cmd_unimpl_i,
    .cmd_seq_ok_i, .cmd_has_ack_i, .ack_en_i, .csr_wr_i, .csr_wdata_i,
    .enable_wr_i, .enable_val_i, .ack_o);

  // Core clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Byte and flag comparisons
  task automatic chk_v(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v

  // Acknowledge length comparisons
  task automatic chk_ack(input string nm, input dsac_pkg::dsac_ack_t e);
    n_checks++;
    if (ack !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, ack);
    end
  endtask : chk_ack

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // One-cycle event pulse; returns once the status byte shows its effect
  task automatic pulse(input int k);
    @(posedge clk_i);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic cmd_always(input logic wr, input logic [7:0] wd);
    host.send(dsac_pkg::DSAC_CMD_ALWAYS, 1'b0, wr, wd, 1'b0, ack);
  endtask : cmd_always

  // Reset with straps; waits a bounded time for readiness
  task automatic do_reset(input logic sec, input logic special_single_chip_mode);
    int n;
    @(posedge clk_i);
    reset_i    <= 1'b1;
    secured_i  <= sec;
    ssc_mode_i <= special_single_chip_mode;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (9) @(posedge clk_i);
    #1 chk_v("ready early", 8'h00, {7'h00, ready_o});
    n = 0;
    while (ready_o !== 1'b1 && n < 6) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk_v("ready", 8'h01, {7'h00, ready_o});
    if (n == 6)
      wrap_up();
  endtask : do_reset

  task automatic t_wait;
    @(posedge clk_i);
    wait_mode_i <= 1'b1;
    settle();
    chk_v("wait set", 8'h80, status_o & 8'h80);
    cmd_always(1'b0, 8'h00);
    chk_ack("first ack", dsac_pkg::DSAC_ACK_LONG);
    cmd_always(1'b0, 8'h00);
    chk_ack("next ack", dsac_pkg::DSAC_ACK_NORMAL);
    cmd_always(1'b1, 8'h80);
    settle();
    chk_v("clear in wait", 8'h80, status_o & 8'h80);
    @(posedge clk_i);
    wait_mode_i <= 1'b0;
    cmd_always(1'b1, 8'h00);
    settle();
    chk_v("zero write", 8'h80, status_o & 8'h80);
    cmd_always(1'b1, 8'h80);
    settle();
    chk_v("clear after", 8'h00, status_o & 8'h80);
  endtask : t_wait

  task automatic t_overrun;
    pulse(5);
    chk_v("ovr set", 8'h10, status_o & 8'h10);
    cmd_always(1'b0, 8'h00);
    chk_ack("ovr pending", dsac_pkg::DSAC_ACK_NORMAL);
    pulse(6);
    cmd_always(1'b0, 8'h00);
    chk_ack("ovr forced", dsac_pkg::DSAC_ACK_LONG);
    cmd_always(1'b1, 8'hFF);
    settle();
    chk_v("ovr write", 8'h10, status_o & 8'h10);
    pulse(4);
    chk_v("ovr sync", 8'h00, status_o & 8'h10);
  endtask : t_overrun

  task automatic t_illegal;
    host.send(dsac_pkg::DSAC_CMD_OTHER, 1'b1, 1'b0, 8'h00, 1'b0, ack);
    chk_v("unimpl long", 8'h00, {7'h00, ack === dsac_pkg::DSAC_ACK_LONG});
    settle();
    chk_v("unimpl flag", 8'h01, status_o & 8'h01);
    cmd_always(1'b0, 8'h00);
    chk_ack("good later", dsac_pkg::DSAC_ACK_NORMAL);
    cmd_always(1'b1, 8'h01);
    host.send(dsac_pkg::DSAC_CMD_ACTIVE, 1'b0, 1'b0, 8'h00, 1'b0, ack);
    chk_ack("inactive cmd", dsac_pkg::DSAC_ACK_LONG);
    chk_v("inactive rej", 8'h01, {7'h00, cmd_rejected_o});
    cmd_always(1'b1, 8'h01);
    settle();
    chk_v("ill clear", 8'h00, status_o & 8'h01);
  endtask : t_illegal

  task automatic t_ram;
    fork
      cmd_always(1'b0, 8'h00);
      pulse(1);
    join
    chk_ack("fault ack", dsac_pkg::DSAC_ACK_LONG);
    chk_v("ram_write_fault_flag set", 8'h20, status_o & 8'h20);
    cmd_always(1'b1, 8'h20);
    settle();
    chk_v("ram_write_fault_flag clear", 8'h00, status_o & 8'h20);
  endtask : t_ram

  task automatic t_enable;
    pulse(0);
    chk_v("stop off", 8'h00, status_o & 8'h40);
    pulse(2);
    settle();
    chk_v("no activation", 8'h00, {7'h00, active_o});
    host.send(dsac_pkg::DSAC_CMD_ALWAYS, 1'b0, 1'b0, 8'h00, 1'b1, ack);
    settle();
    chk_v("enabled", 8'h01, {7'h00, enabled_o});
    stop_mode_i <= 1'b1;
    pulse(0);
    chk_v("stop set", 8'h40, status_o & 8'h40);
    cmd_always(1'b1, 8'h40);
    settle();
    chk_v("stop held", 8'h40, status_o & 8'h40);
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    cmd_always(1'b1, 8'h40);
    settle();
    chk_v("stop clear", 8'h00, status_o & 8'h40);
    pulse(2);
    settle();
    chk_v("activated", 8'h01, {7'h00, active_o});
  endtask : t_enable

  task automatic t_nvm;
    @(posedge clk_i);
    nvm_init_i <= 1'b1;
    host.send(dsac_pkg::DSAC_CMD_OTHER, 1'b0, 1'b0, 8'h00, 1'b0, ack);
    chk_ack("init delayed", dsac_pkg::DSAC_ACK_NONE);
    chk_v("init no go", 8'h00, {7'h00, cmd_go_o});
    cmd_always(1'b0, 8'h00);
    chk_ack("init always", dsac_pkg::DSAC_ACK_NORMAL);
    chk_v("init go", 8'h01, {7'h00, cmd_go_o});
    nvm_init_i <= 1'b0;
  endtask : t_nvm

  task automatic t_secure;
    do_reset(1'b1, 1'b0);
    chk_v("unsecured_status_bit clear", 8'h00, {7'h00, unsecured_status_bit_o});
    mem_rdata_i <= 8'h5A;
    host.send(dsac_pkg::DSAC_CMD_READ, 1'b0, 1'b0, 8'h00, 1'b0, ack);
    chk_v("secure read", 8'hEE, rdata_o);
    chk_v("secure rej", 8'h01, {7'h00, cmd_rejected_o});
    pulse(3);
    settle();
    chk_v("erase fail", 8'h00, {7'h00, unsecured_status_bit_o});
    erase_ok_i <= 1'b1;
    pulse(3);
    settle();
    chk_v("erase ok", 8'h01, {7'h00, unsecured_status_bit_o});
  endtask : t_secure

  // Main sequence
  initial begin
    {reset_i, secured_i, ssc_mode_i, wait_mode_i, stop_mode_i} = 5'h00;
    {nvm_init_i, processor_background_instruction_instr_i, breakpoint_i, erase_ok_i} = 4'h0;
    {erase_busy_i, ev, mem_rdata_i} = 16'h0000;
    clk_en_i  = 1'b1;
    err_count = 0;
    n_checks  = 0;
    do_reset(1'b0, 1'b0);
    t_wait();
    t_overrun();
    t_illegal();
    t_ram();
    t_enable();
    t_nvm();
    t_secure();
    do_reset(1'b0, 1'b1);
    chk_v("ssc active", 8'h01, {7'h00, active_o});
    // Host supplies the start address first; still disabled, so refused
    host.send(dsac_pkg::DSAC_CMD_ACTIVE, 1'b0, 1'b0, 8'h00, 1'b0, ack);
    chk_v("pc write rej", 8'h01, {7'h00, cmd_rejected_o});
    wrap_up();
  end
endmodule : debug_status_ack_control_bench

// ### dsac_cfg.svh
`ifndef DSAC_CFG_SVH
`define DSAC_CFG_SVH
// Flag vector indices (BIT) and status byte field positions (POS)
`define DSAC_BIT_WAIT     3
`define DSAC_BIT_STOP     2
`define DSAC_BIT_RAM_WRITE_FAULT_FLAG    1
`define DSAC_BIT_ILL      0
`define DSAC_POS_WAIT     7
`define DSAC_POS_STOP     6
`define DSAC_POS_RAM_WRITE_FAULT_FLAG    5
`define DSAC_POS_OVRN     4
`define DSAC_POS_ILL      0
// Reset value of the status byte
`define DSAC_STATUS_RST   8'h00
// Data returned by reads refused while secure
`define DSAC_SECURE_DATA  8'hEE
// Core cycles from internal reset release to first command
`define DSAC_READY_CYCLES 10
`endif

// ### dsac_debug_status.sv
`timescale 1ns/10ps
`include "dsac_cfg.svh"

// Notes on behaviour
// [RULE_01] Status byte only via debug link commands
// [RULE_02] Writing one clears flags, zero ignored
// [RULE_03] Overrun flag cleared only by sync
// [RULE_04] Flag-setting acked command gets long ack
// [RULE_05] Later good commands normal, bad long
// [RULE_06] First ack after wait/stop set long
// [RULE_07] Overrun forces long acks after next byte
// [RULE_08] Unimplemented opcode gives no long ack
// [RULE_09] Wait flag clears only after wait exit
// [RULE_10] Stop flag sets if enabled; clear outside
// [RULE_11] RAM ECC fault sets flag, one clears
// [RULE_12] Illegal command flag set conditions
// [RULE_13] Secure-rejected reads return 0xEE bytes
// [RULE_14] Secure reset clears unsecured bit, restricts
// [RULE_15] Mass erase success unsecures, failure stays
// [RULE_16] Debug mode needs enable before activation
// [RULE_17] Special single-chip reset activates debug
// [RULE_18] Ready ten core cycles after reset
// [RULE_19] Init phase delays non-always commands
// [RULE_20] Host writes PC before go after reset
module dsac_debug_status (
  // Clock, enable and reset
  input  wire logic               clk_i,
  input  wire logic               clk_en_i,
  input  wire logic               reset_i,
  // Device state at reset and mode inputs
  input  wire logic               secured_i,
  input  wire logic               ssc_mode_i,
  input  wire logic               wait_mode_i,
  input  wire logic               stop_req_i,
  input  wire logic               stop_mode_i,
  input  wire logic               ram_ecc_fault_i,
  input  wire logic               nvm_init_i,
  // Activation sources
  input  wire logic               processor_background_instruction_cmd_i,
  input  wire logic               processor_background_instruction_instr_i,
  input  wire logic               breakpoint_i,
  // Mass erase result
  input  wire logic               erase_done_i,
  input  wire logic               erase_ok_i,
  input  wire logic               erase_busy_i,
  // Link byte and sync events
  input  wire logic               sync_i,
  input  wire logic               host_low_pend_i,
  input  wire logic               byte_rx_i,
  // Decoded command
  input  wire logic               cmd_valid_i,
  input  wire dsac_pkg::dsac_cmd_t cmd_class_i,
  input  wire logic               cmd_unimpl_i,
  input  wire logic               cmd_seq_ok_i,
  input  wire logic               cmd_has_ack_i,
  input  wire logic               ack_en_i,
  // Control/status byte access from the link
  input  wire logic               csr_wr_i,
  input  wire logic [7:0]         csr_wdata_i,
  input  wire logic               enable_wr_i,
  input  wire logic               enable_val_i,
  input  wire logic [7:0]         mem_rdata_i,
  // Outputs
  output logic [7:0]              status_o,
  output logic [7:0]              rdata_o,
  output dsac_pkg::dsac_ack_t     ack_o,
  output logic                    cmd_go_o,
  output logic                    cmd_rejected_o,
  output logic                    ready_o,
  output logic                    enabled_o,
  output logic                    active_o,
  output logic                    unsecured_status_bit_o
);

  // Internal state
  logic       ready_w;
  logic [3:0] flags_w;
  logic       ovrn_q;
  logic       ovrn_armed_q;
  logic       ovrn_live_q;
  logic       ws_seen_q;
  logic       enable_q;
  logic       active_q;
  logic       unsecured_status_bit_q;
  logic       ssc_q;
  logic       rst_seen_q;

  // Command classification
  wire take_w     = cmd_valid_i & ready_w;
  wire restrict_w = (cmd_class_i != dsac_pkg::DSAC_CMD_ALWAYS);
  wire secure_w   = ~unsecured_status_bit_q;
  wire ill_active = (cmd_class_i == dsac_pkg::DSAC_CMD_ACTIVE) & ~active_q;
  wire ill_seq    = (cmd_class_i == dsac_pkg::DSAC_CMD_SEQ) & ~cmd_seq_ok_i;
  wire ill_rstr   = restrict_w & (~enable_q | erase_busy_i | secure_w);
  // An unimplemented opcode has no class, so it never counts as other cause
  wire ill_other  = (ill_active | ill_seq | ill_rstr) & ~cmd_unimpl_i; // RULE_12
  wire ill_set    = take_w & (cmd_unimpl_i | ill_other); // RULE_12
  // Non-always commands wait out the init phase
  wire delay_w    = nvm_init_i & restrict_w; // RULE_19
  wire exec_w     = take_w & ~delay_w & ~cmd_unimpl_i & ~ill_other;
  wire ram_set    = ram_ecc_fault_i;
  wire stop_set   = stop_req_i & enable_q; // RULE_10
  wire ws_any     = flags_w[`DSAC_BIT_WAIT] | flags_w[`DSAC_BIT_STOP];
  wire flag31_set = ram_set | stop_set | (take_w & ill_other);
  wire wr_w       = csr_wr_i & take_w;

  // Readiness after internal reset
  dsac_ready_timer #(
    .CYCLES (`DSAC_READY_CYCLES)
  ) u_ready (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .clk_en_i (clk_en_i),
    .ready_o  (ready_w) // RULE_18
  );

  // Sticky flags with write-one-to-clear; blocks hold while mode lasts
  logic [3:0] set_v;
  logic [3:0] blk_v;
  logic [3:0] clr_v;
  assign set_v = {wait_mode_i, stop_set, ram_set, ill_set}; // RULE_09
  assign blk_v = {wait_mode_i, stop_mode_i, 1'b0, 1'b0}; // RULE_10
  assign clr_v = {csr_wdata_i[`DSAC_POS_WAIT],
                  csr_wdata_i[`DSAC_POS_STOP],
                  csr_wdata_i[`DSAC_POS_RAM_WRITE_FAULT_FLAG],
                  csr_wdata_i[`DSAC_POS_ILL]} & {4{wr_w}}; // RULE_02
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      dsac_flag_bit u_flag (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .clk_en_i    (clk_en_i),
        .set_i       (set_v[gi]), // RULE_11
        .clr_i       (clr_v[gi]),
        .clr_block_i (blk_v[gi]),
        .flag_o      (flags_w[gi])
      );
    end
  endgenerate

  // Overrun: set by host low while ack pends, cleared only by sync
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ovrn_q       <= 1'b0;
      ovrn_armed_q <= 1'b0;
      ovrn_live_q  <= 1'b0;
    end else if (clk_en_i) begin
      if (host_low_pend_i) begin
        ovrn_q       <= 1'b1;
        ovrn_armed_q <= 1'b1;
        ovrn_live_q  <= 1'b0; // RULE_07
      end else if (sync_i) begin
        ovrn_q       <= 1'b0; // RULE_03
        ovrn_armed_q <= 1'b0;
        ovrn_live_q  <= 1'b0;
      end else if (ovrn_armed_q && byte_rx_i) begin
        ovrn_armed_q <= 1'b0;
        ovrn_live_q  <= 1'b1; // RULE_07
      end
    end
  end

  // Wait/stop first-ack tracker: re-armed whenever both flags drop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ws_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!ws_any) begin
        ws_seen_q <= 1'b0;
      end else if (take_w && cmd_has_ack_i && ack_en_i) begin
        ws_seen_q <= 1'b1; // RULE_06
      end
    end
  end

  // Acknowledge length selection
  dsac_pkg::dsac_ack_t ack_d;
  wire bad_cmd   = take_w & ill_other; // RULE_08
  wire need_long = bad_cmd | flag31_set | ovrn_live_q |
                   (ws_any & ~ws_seen_q); // RULE_04 RULE_05 RULE_06
  always_comb begin
    ack_d = dsac_pkg::DSAC_ACK_NONE;
    if (take_w && cmd_has_ack_i && ack_en_i && !delay_w) begin
      if (need_long) begin
        ack_d = dsac_pkg::DSAC_ACK_LONG; // RULE_04
      end else begin
        ack_d = dsac_pkg::DSAC_ACK_NORMAL; // RULE_05
      end
    end
  end

  // Read data: refused reads while secure give the fixed byte
  wire [7:0] status_w = {flags_w[`DSAC_BIT_WAIT], flags_w[`DSAC_BIT_STOP],
                         flags_w[`DSAC_BIT_RAM_WRITE_FAULT_FLAG], ovrn_q, 3'b000,
                         flags_w[`DSAC_BIT_ILL]}; // RULE_01
  wire sec_read = take_w & secure_w &
                  (cmd_class_i == dsac_pkg::DSAC_CMD_READ);
  wire [7:0] rdata_d = sec_read ? `DSAC_SECURE_DATA : mem_rdata_i; // RULE_13

  // Enable, activation and security state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      enable_q   <= 1'b0;
      active_q   <= 1'b0;
      unsecured_status_bit_q    <= 1'b0;
      ssc_q      <= 1'b0;
      rst_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!rst_seen_q) begin
        // Straps are caught on the first enabled edge after release
        rst_seen_q <= 1'b1;
        ssc_q      <= ssc_mode_i;
        active_q   <= ssc_mode_i; // RULE_17
        unsecured_status_bit_q    <= ~secured_i; // RULE_14
      end else begin
        if (enable_wr_i && take_w) begin
          enable_q <= enable_val_i; // RULE_16
        end
        if (enable_q && (processor_background_instruction_cmd_i || processor_background_instruction_instr_i || breakpoint_i)) begin
          active_q <= 1'b1; // RULE_16
        end
        if (erase_done_i && erase_ok_i) begin
          unsecured_status_bit_q <= 1'b1; // RULE_15
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_o       <= `DSAC_STATUS_RST;
      rdata_o        <= 8'h00;
      ack_o          <= dsac_pkg::DSAC_ACK_NONE;
      cmd_go_o       <= 1'b0;
      cmd_rejected_o <= 1'b0;
      ready_o        <= 1'b0;
      enabled_o      <= 1'b0;
      active_o       <= 1'b0;
      unsecured_status_bit_o        <= 1'b0;
    end else if (clk_en_i) begin
      status_o       <= status_w;
      rdata_o        <= rdata_d;
      ack_o          <= ack_d;
      cmd_go_o       <= exec_w; // RULE_19
      cmd_rejected_o <= ill_set;
      ready_o        <= ready_w;
      enabled_o      <= enable_q;
      active_o       <= active_q;
      unsecured_status_bit_o        <= unsecured_status_bit_q; // RULE_14
    end
  end

  // Checks
  chk_sec_read_ee: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && sec_read |=> rdata_o == 8'hEE) // RULE_13
    else $error("secure read did not return fixed byte");
  chk_ovrn_no_wr: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && ovrn_q && !sync_i |=> ovrn_q) // RULE_03
    else $error("overrun flag cleared without sync");
  chk_ill_long: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && bad_cmd && cmd_has_ack_i && ack_en_i && !delay_w
    |=> ack_o == dsac_pkg::DSAC_ACK_LONG) // RULE_08
    else $error("illegal command did not get long ack");
  chk_unimpl_ack: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && take_w && cmd_unimpl_i && !need_long
    |=> ack_o != dsac_pkg::DSAC_ACK_LONG) // RULE_08
    else $error("unimplemented opcode gave long ack");
  chk_ovrn_long: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && ovrn_live_q && ack_d != dsac_pkg::DSAC_ACK_NONE
    |=> ack_o == dsac_pkg::DSAC_ACK_LONG) // RULE_07
    else $error("overrun did not force long ack");
  chk_wait_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && wait_mode_i |=> flags_w[`DSAC_BIT_WAIT]) // RULE_09
    else $error("wait flag not held in wait mode");
  chk_stop_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !flags_w[`DSAC_BIT_STOP] && stop_req_i && !enable_q
    |=> !flags_w[`DSAC_BIT_STOP]) // RULE_10
    else $error("stop flag set while disabled");
  chk_ram_set: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && ram_ecc_fault_i |=> flags_w[`DSAC_BIT_RAM_WRITE_FAULT_FLAG]) // RULE_11
    else $error("ram fault flag not set");
  chk_active_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && rst_seen_q && !active_q && !enable_q |=> !active_q) // RULE_16
    else $error("debug mode activated while disabled");
  chk_ready_time: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(ready_w) |-> $past(clk_en_i)) // RULE_18
    else $error("ready rose without counting");
  chk_delay_go: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && take_w && delay_w |=> !cmd_go_o) // RULE_19
    else $error("restricted command ran during init phase");

endmodule : dsac_debug_status

// ### dsac_flag_bit.sv
`timescale 1ns/10ps
// One write-one-to-clear sticky flag; set beats clear
module dsac_flag_bit (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  // Control
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic clr_block_i,
  // State
  output logic      flag_o
);
  logic flag_d;
  assign flag_d = set_i | (flag_o & ~(clr_i & ~clr_block_i));
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_o <= 1'b0;
    end else if (clk_en_i) begin
      flag_o <= flag_d;
    end
  end
endmodule : dsac_flag_bit

// ### dsac_host_model.sv
`timescale 1ns/10ps
// Debug host side: one decoded command per call
module dsac_host_model (
  // Clock
  input  wire logic                clk_i,
  // Decoded command towards the block
  output logic                     cmd_valid_i,
  output dsac_pkg::dsac_cmd_t      cmd_class_i,
  output logic                     cmd_unimpl_i,
  output logic                     cmd_seq_ok_i,
  output logic                     cmd_has_ack_i,
  output logic                     ack_en_i,
  output logic                     csr_wr_i,
  output logic [7:0]               csr_wdata_i,
  output logic                     enable_wr_i,
  output logic                     enable_val_i,
  // Acknowledge from the block
  input  wire dsac_pkg::dsac_ack_t ack_o
);
  // Handshaking stays on so that every ack length can be seen
  initial begin
    {cmd_valid_i, cmd_unimpl_i, csr_wr_i, enable_wr_i} = 4'h0;
    {cmd_seq_ok_i, cmd_has_ack_i, ack_en_i, enable_val_i} = 4'hF;
    cmd_class_i = dsac_pkg::DSAC_CMD_ALWAYS;
    csr_wdata_i = 8'h00;
  end

  // Hold a command over its taking edge, then read the answer
  task automatic send(input dsac_pkg::dsac_cmd_t cls, input logic un,
                      input logic wr, input logic [7:0] wd, input logic en,
                      output dsac_pkg::dsac_ack_t ack);
    @(posedge clk_i);
    cmd_valid_i  <= 1'b1;
    cmd_class_i  <= cls;
    cmd_unimpl_i <= un;
    csr_wr_i     <= wr;
    csr_wdata_i  <= wd;
    enable_wr_i  <= en;
    @(posedge clk_i);
    cmd_valid_i  <= 1'b0;
    csr_wr_i     <= 1'b0;
    enable_wr_i  <= 1'b0;
    csr_wdata_i  <= ~wd; // A released bus must not echo the last byte
    #1 ack = ack_o;
  endtask : send
endmodule : dsac_host_model

// ### dsac_pkg.sv
package dsac_pkg;
  // Acknowledge length requested for one command
  typedef enum logic [1:0] {
    DSAC_ACK_NONE,
    DSAC_ACK_NORMAL,
    DSAC_ACK_LONG
  } dsac_ack_t;
  // Command class decoded by the link front end
  typedef enum logic [2:0] {
    DSAC_CMD_ALWAYS,
    DSAC_CMD_ACTIVE,
    DSAC_CMD_SEQ,
    DSAC_CMD_READ,
    DSAC_CMD_OTHER
  } dsac_cmd_t;
endpackage : dsac_pkg

// ### dsac_ready_timer.sv
`timescale 1ns/10ps
`include "dsac_cfg.svh"
// Counts core cycles after internal reset release
module dsac_ready_timer #(
  parameter int CYCLES = `DSAC_READY_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  // Status
  output logic      ready_o
);
  logic [4:0] cnt_q;
  // Count up once out of reset, then hold
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 5'h00;
    end else if (clk_en_i && !ready_o) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  assign ready_o = (cnt_q >= 5'(CYCLES));
endmodule : dsac_ready_timer
